// *** common/sts_pkg.sv ***
// Purpose: shared constants and carriers for the sweep timing supervisor
// Assumes: 50 MHz system clock, all time bases counted in 100 us ticks
// Notes:   every count below is derived from its printed time figure
package sts_pkg;
  // ****************************************************************
  // time base
  // ****************************************************************
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int TICKS_PER_S = 1000000 / TICK_US;
  // ****************************************************************
  // watchdog and constant sweep times, in ms
  // ****************************************************************
  localparam int WD_TOTAL_MS = 200;
  localparam int WD_STAGE1_MS = 100;
  localparam int WD_STAGE2_MS = 105;
  localparam int CS_MIN_MS = 5;
  localparam int CS_MAX_MS = 200;
  localparam int CS_DEF_MS = 100;
  // timed contact periods in ms: 0.01 s, 0.1 s, 1 s, 1 min
  localparam int CT0_MS = 10;
  localparam int CT1_MS = 100;
  localparam int CT2_MS = 1000;
  localparam int CT3_MS = 60000;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ELAPSED_W = 48;
  localparam int SECONDS_W = 32;
  localparam int SUBSEC_W = 14;
  localparam int WD_CNT_W = 12;
  localparam int CS_CNT_W = 12;
  localparam int CS_MS_W = 8;
  localparam int CT_CNT_W = 20;
  localparam int PRE_W = 16;
  localparam int NUM_CT = 4;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {WD_STAGE1, WD_STAGE2, WD_HALT} sts_wd_e;
  typedef struct packed {
    logic cs_enable;
    logic [CS_MS_W-1:0] cs_period_ms;
  } sts_ctl_s;
  typedef struct packed {
    logic wd_irq;
    logic wd_reset;
    logic wd_fault;
    logic halted;
  } sts_wd_s;
  typedef struct packed {
    logic sweep_go;
    logic oversweep_flag;
    logic oversweep_alarm;
  } sts_swp_s;
endpackage

// *** logic/sts_sweep_timing_supervisor.sv ***
// Purpose: elapsed clock, two-stage watchdog, constant sweep timer and
//          timed contacts for a controller's scan loop
// Assumes: processor inputs are one-cycle pulses synchronous to mclk
// Notes:   only arst_n clears the elapsed clock
`timescale 1ns/1ps
module sts_sweep_timing_supervisor #(
  parameter int unsigned TICK_CYC = sts_pkg::TICK_CYC
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // power-on reset, active low
  input wire logic sweep_start, // pulse: processor begins a sweep
  input wire logic sweep_done, // pulse: scan and logic complete
  input wire logic wdt_rearm, // pulse: firmware arms stage two
  input wire logic service_request_call, // pulse: read elapsed
  input sts_pkg::sts_ctl_s ctl, // constant sweep mode and period
  output logic [sts_pkg::ELAPSED_W-1:0] elapsed_rd, // snapshot, ticks
  output logic elapsed_rd_valid, // pulse: snapshot updated
  output logic [sts_pkg::SECONDS_W-1:0] seconds, // seconds count
  output logic sec_irq, // pulse: one second elapsed
  output sts_pkg::sts_wd_s wd, // watchdog status
  output sts_pkg::sts_swp_s swp, // sweep pacing status
  output logic [sts_pkg::NUM_CT-1:0] contacts // timed contacts
);
  // ****************************************************************
  // constants
  // ****************************************************************
  localparam int EW = sts_pkg::ELAPSED_W;
  localparam int SW = sts_pkg::SECONDS_W;
  localparam int SSW = sts_pkg::SUBSEC_W;
  localparam int WW = sts_pkg::WD_CNT_W;
  localparam int CW = sts_pkg::CS_CNT_W;
  localparam int MW = sts_pkg::CS_MS_W;
  localparam int TW = sts_pkg::CT_CNT_W;
  localparam int PW = sts_pkg::PRE_W;
  localparam int NC = sts_pkg::NUM_CT;
  localparam int TPM = sts_pkg::TICKS_PER_MS;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);
  localparam logic [SSW-1:0] SUB_LAST = SSW'(sts_pkg::TICKS_PER_S - 1);
  localparam logic [WW-1:0] WD_S1_T = WW'(sts_pkg::WD_STAGE1_MS * TPM);
  localparam logic [WW-1:0] WD_S2_T = WW'(sts_pkg::WD_STAGE2_MS * TPM);
  localparam logic [WW-1:0] WD_TOT_T = WW'(sts_pkg::WD_TOTAL_MS * TPM);
  localparam logic [MW-1:0] CS_MIN = MW'(sts_pkg::CS_MIN_MS);
  localparam logic [MW-1:0] CS_MAX = MW'(sts_pkg::CS_MAX_MS);
  localparam logic [MW-1:0] CS_DEF = MW'(sts_pkg::CS_DEF_MS);
  localparam logic [TW-1:0] CT_LAST [NC] = '{
    TW'(sts_pkg::CT0_MS * TPM / 2 - 1),
    TW'(sts_pkg::CT1_MS * TPM / 2 - 1),
    TW'(sts_pkg::CT2_MS * TPM / 2 - 1),
    TW'(sts_pkg::CT3_MS * TPM / 2 - 1)
  };

  // period in ticks; zero selects the default, others clamp to range
  function automatic logic [CW-1:0] cs_ticks(input logic [MW-1:0] ms);
    logic [MW-1:0] m;
    m = ms;
    if (ms == '0) begin
      m = CS_DEF;
    end else if (ms < CS_MIN) begin
      m = CS_MIN;
    end else if (ms > CS_MAX) begin
      m = CS_MAX;
    end
    return CW'(m * TPM);
  endfunction

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [PW-1:0] pre_r;
  // free running, so each timer start carries up to one tick of phase
  wire logic tick = (pre_r == PRE_LAST);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
    end
  end

  // ****************************************************************
  // elapsed time clock
  // ****************************************************************
  logic [EW-1:0] elapsed_r;
  logic [SSW-1:0] subsec_r;
  logic [SW-1:0] seconds_r;
  logic sec_irq_r;
  logic [EW-1:0] elapsed_rd_r;
  logic rd_valid_r;
  wire logic sec_wrap = tick & (subsec_r == SUB_LAST);

  // nothing but power-on reset reaches these counters
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      elapsed_r <= '0;
      subsec_r <= '0;
      seconds_r <= '0;
      sec_irq_r <= 1'b0;
      elapsed_rd_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      if (tick) begin
        elapsed_r <= elapsed_r + 1'b1;
        subsec_r <= sec_wrap ? '0 : subsec_r + 1'b1;
      end
      if (sec_wrap) begin
        seconds_r <= seconds_r + 1'b1;
      end
      sec_irq_r <= sec_wrap;
      rd_valid_r <= service_request_call;
      if (service_request_call) begin
        elapsed_rd_r <= elapsed_r;
      end
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  sts_pkg::sts_wd_e wd_state_r, wd_state_nxt;
  logic [WW-1:0] wd_cnt_r, wd_cnt_nxt;
  logic wd_irq_r, wd_irq_nxt;
  logic wd_rst_r, wd_fault_r;
  logic wd_trip;
  // a sweep start outranks a same-cycle stage one expiry: the count
  // restarts, so a stale interrupt must not reach the new sweep

  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_cnt_nxt = tick ? wd_cnt_r + 1'b1 : wd_cnt_r;
    wd_irq_nxt = wd_irq_r;
    wd_trip = 1'b0;
    case (wd_state_r)
      sts_pkg::WD_STAGE1: begin
        if (sweep_start) begin
          wd_cnt_nxt = '0;
          wd_irq_nxt = 1'b0;
        end else if (wdt_rearm && wd_irq_r) begin
          wd_state_nxt = sts_pkg::WD_STAGE2;
          wd_cnt_nxt = '0;
          wd_irq_nxt = 1'b0;
        end else if (wd_cnt_r >= WD_TOT_T) begin
          // backstop: firmware never armed stage two
          wd_trip = 1'b1;
        end else if (wd_cnt_r >= WD_S1_T) begin
          wd_irq_nxt = 1'b1;
        end
      end
      sts_pkg::WD_STAGE2: begin
        if (sweep_start) begin
          wd_state_nxt = sts_pkg::WD_STAGE1;
          wd_cnt_nxt = '0;
        end else if (wd_cnt_r >= WD_S2_T) begin
          wd_trip = 1'b1;
        end
      end
      sts_pkg::WD_HALT: begin
        wd_cnt_nxt = wd_cnt_r;
      end
      default: begin
        wd_state_nxt = sts_pkg::WD_STAGE1;
        wd_cnt_nxt = '0;
      end
    endcase
    if (wd_trip) begin
      wd_state_nxt = sts_pkg::WD_HALT;
      wd_irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wd_state_r <= sts_pkg::WD_STAGE1;
      wd_cnt_r <= '0;
      wd_irq_r <= 1'b0;
      wd_rst_r <= 1'b0;
      wd_fault_r <= 1'b0;
    end else begin
      wd_state_r <= wd_state_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_irq_r <= wd_irq_nxt;
      wd_rst_r <= wd_trip;
      wd_fault_r <= wd_fault_r | wd_trip;
    end
  end

  wire logic halted = (wd_state_r == sts_pkg::WD_HALT);

  // ****************************************************************
  // constant sweep timer
  // ****************************************************************
  logic [CW-1:0] cs_cnt_r;
  logic expired_r, done_r, cur_inc_r, prev_inc_r, ovf_r, alarm_r;
  wire logic cs_en = ctl.cs_enable;
  wire logic [CW-1:0] cs_period = cs_ticks(ctl.cs_period_ms);
  wire logic expire_now = ~expired_r & (cs_cnt_r >= cs_period);
  wire logic overrun = cs_en & expire_now & ~done_r & ~sweep_done;
  // a sweep that completes in the expiry cycle itself counts as on time

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cs_cnt_r <= '0;
      expired_r <= 1'b0;
      done_r <= 1'b0;
      cur_inc_r <= 1'b0;
      prev_inc_r <= 1'b0;
      ovf_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= overrun & prev_inc_r;
      if (sweep_start) begin
        cs_cnt_r <= '0;
        expired_r <= 1'b0;
        done_r <= 1'b0;
        prev_inc_r <= cur_inc_r;
        cur_inc_r <= 1'b0;
        ovf_r <= cs_en & cur_inc_r;
      end else begin
        if (tick && !expired_r) begin
          cs_cnt_r <= cs_cnt_r + 1'b1;
        end
        if (expire_now) begin
          expired_r <= 1'b1;
        end
        if (sweep_done) begin
          done_r <= 1'b1;
        end
        if (overrun) begin
          cur_inc_r <= 1'b1;
        end
        if (!cs_en) begin
          ovf_r <= 1'b0;
        end
      end
    end
  end

  // free mode releases as soon as the sweep ends; constant mode also
  // waits for the period, so an overrun sweep ends at its own finish
  wire logic sweep_go = ~halted & done_r & (~cs_en | expired_r);

  // ****************************************************************
  // timed contacts
  // ****************************************************************
  logic [TW-1:0] ct_cnt_r [NC];
  logic [NC-1:0] ct_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NC; i++) begin
        ct_cnt_r[i] <= '0;
      end
      ct_r <= '0;
    end else if (tick) begin
      for (int i = 0; i < NC; i++) begin
        if (ct_cnt_r[i] == CT_LAST[i]) begin
          ct_cnt_r[i] <= '0;
          ct_r[i] <= ~ct_r[i];
        end else begin
          ct_cnt_r[i] <= ct_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign elapsed_rd = elapsed_rd_r;
  assign elapsed_rd_valid = rd_valid_r;
  assign seconds = seconds_r;
  assign sec_irq = sec_irq_r;
  assign wd.wd_irq = wd_irq_r;
  assign wd.wd_reset = wd_rst_r;
  assign wd.wd_fault = wd_fault_r;
  assign wd.halted = halted;
  assign swp.sweep_go = sweep_go;
  assign swp.oversweep_flag = ovf_r;
  assign swp.oversweep_alarm = alarm_r;
  assign contacts = ct_r;

endmodule // sts_sweep_timing_supervisor

// *** sim/sts_sup_properties.sv ***
// Purpose: concurrent checks on the supervisor ports
// Assumes: one clock domain, asynchronous active low reset
// Notes:   bound into every supervisor instance
`timescale 1ns/1ps
module sts_sup_properties #(
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // reset, active low
  input wire logic sweep_start, // sweep begins
  input wire logic wdt_rearm, // stage two arm
  input wire logic service_request_call, // snapshot request
  input sts_pkg::sts_ctl_s ctl, // sweep mode
  input wire logic elapsed_rd_valid, // snapshot ready
  input wire logic sec_irq, // seconds pulse
  input wire logic [sts_pkg::NUM_CT-1:0] contacts, // timed contacts
  input sts_pkg::sts_wd_s wd, // watchdog status
  input sts_pkg::sts_swp_s swp // pacing status
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ****
  // watchdog
  // ****
  property p_rst_pulse;
    wd.wd_reset |=> !wd.wd_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("watchdog reset longer than one cycle");
  property p_trip_halts;
    wd.wd_reset |=> wd.wd_fault && wd.halted;
  endproperty
  a_trip_halts: assert property (p_trip_halts)
    else $error("trip without fault and halt");
  property p_fault_sticky;
    wd.wd_fault |=> wd.wd_fault;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault dropped without reset");
  property p_halt_idle;
    wd.halted |-> !swp.sweep_go;
  endproperty
  a_halt_idle: assert property (p_halt_idle)
    else $error("sweep allowed while halted");
  property p_rearm;
    wd.wd_irq && wdt_rearm && !wd.halted |=> !wd.wd_irq;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("interval interrupt not cleared by rearm");
  property p_start_clr;
    sweep_start && !wd.halted |=> !wd.wd_irq;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("interval interrupt not cleared by sweep");
  // ****
  // time base and pacing
  // ****
  property p_rd_ans;
    service_request_call |=> elapsed_rd_valid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("snapshot not answered next cycle");
  property p_sec_pulse;
    sec_irq |=> !sec_irq [*8];
  endproperty
  a_sec_pulse: assert property (p_sec_pulse)
    else $error("seconds interrupt repeated too soon");
  property p_flag_off;
    !ctl.cs_enable |=> !swp.oversweep_flag;
  endproperty
  a_flag_off: assert property (p_flag_off)
    else $error("oversweep flag set in free mode");
  property p_alarm_pulse;
    swp.oversweep_alarm |=> !swp.oversweep_alarm;
  endproperty
  a_alarm_pulse: assert property (p_alarm_pulse)
    else $error("alarm longer than one cycle");
  property p_ct_hold;
    $changed(contacts[0]) |=> $stable(contacts[0]) [*8];
  endproperty
  a_ct_hold: assert property (p_ct_hold)
    else $error("fastest contact toggled too soon");
endmodule // sts_sup_properties
bind sts_sweep_timing_supervisor sts_sup_properties #(
  .TICK_CYC(TICK_CYC)
) u_props (.mclk(mclk), .arst_n(arst_n), .sweep_start(sweep_start),
  .wdt_rearm(wdt_rearm), .service_request_call(service_request_call),
  .ctl(ctl), .elapsed_rd_valid(elapsed_rd_valid), .sec_irq(sec_irq),
  .contacts(contacts), .wd(wd), .swp(swp));

// *** sim/sts_cpu_model.sv ***
// Purpose: processor core running sweeps and servicing the watchdog
// Assumes: drives on the falling edge, pulses one cycle wide
// Notes:   a huge done delay models a sweep that never completes
`timescale 1ns/1ps
module sts_cpu_model (
  input wire logic mclk, // system clock
  input wire logic arst_n, // reset, active low
  input wire logic run, // keep sweeping
  input int done_dly, // cycles from start to done
  input wire logic wd_irq, // stage one interrupt
  input wire logic sweep_go, // next sweep allowed
  output logic sweep_start, // sweep begins
  output logic sweep_done, // sweep complete
  output logic wdt_rearm // arm stage two
);
  logic busy;
  logic first;
  int cnt;
  always @(negedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy = 0;
      first = 1;
      cnt = 0;
      sweep_start = 0;
      sweep_done = 0;
      wdt_rearm = 0;
    end else begin
      sweep_start = run && !busy && (sweep_go || first);
      sweep_done = busy && cnt == done_dly;
      // never stalls, so the interrupt is always serviced
      wdt_rearm = wd_irq && !wdt_rearm;
      if (sweep_start) begin
        busy = 1;
        first = 0;
        cnt = 1;
      end else if (sweep_done) begin
        busy = 0;
      end else begin
        cnt++;
      end
    end
  end
endmodule // sts_cpu_model

// *** sim/sts_sweep_timing_supervisor_tb.sv ***
// Purpose: self-checking bench for the sweep timing supervisor
// Assumes: tick shortened to 4 cycles, so 1 ms is 40 cycles
// Notes:   the minute contact is too slow to time here
`timescale 1ns/1ps
module sts_sweep_timing_supervisor_tb;
  logic mclk = 0;
  logic arst_n = 0;
  logic src = 0;
  logic run = 0;
  int dly = 5;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  int trel;
  localparam int TCK = 4;
  localparam int TPM = sts_pkg::TICKS_PER_MS;
  localparam int HC0 = sts_pkg::CT0_MS * TPM / 2 * TCK;
  localparam int HC1 = sts_pkg::CT1_MS * TPM / 2 * TCK;
  localparam int HC2 = sts_pkg::CT2_MS * TPM / 2 * TCK;
  localparam int SEC = sts_pkg::TICKS_PER_S * TCK;
  sts_pkg::sts_ctl_s ctl = '0;
  logic ss, sd, rearm, rd_v, sirq;
  logic [47:0] rd;
  logic [31:0] secs;
  logic [3:0] ct;
  sts_pkg::sts_wd_s wd;
  sts_pkg::sts_swp_s swp;
  wire logic [8:0] ev = {ct[2], ct[1], ~ct[0], ct[0],
    swp.oversweep_alarm, sirq, wd.wd_reset, wd.wd_irq, ss};
  sts_sweep_timing_supervisor #(.TICK_CYC(TCK)) dut (.mclk(mclk),
    .arst_n(arst_n), .sweep_start(ss), .sweep_done(sd),
    .wdt_rearm(rearm), .service_request_call(src), .ctl(ctl),
    .elapsed_rd(rd), .elapsed_rd_valid(rd_v), .seconds(secs),
    .sec_irq(sirq), .wd(wd), .swp(swp), .contacts(ct));
  sts_cpu_model cpu (.mclk(mclk), .arst_n(arst_n), .run(run),
    .done_dly(dly), .wd_irq(wd.wd_irq), .sweep_go(swp.sweep_go),
    .sweep_start(ss), .sweep_done(sd), .wdt_rearm(rearm));
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 99000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [47:0] seen,
      input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // sampled just after the edge so registered outputs have settled
  task automatic await(input int b, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (ev[b] !== 1'b1 && n < lim);
    chk("event", ev[b], 1);
  endtask
  task tally_and_finish;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    arst_n = 1;
    trel = cyc;
    chk("seconds", secs, 0);
    run = 1;
    repeat (400) @(negedge mclk);
    src = 1;
    @(posedge mclk);
    #1;
    chk("rd valid", rd_v, 1);
    chk("elapsed", rd inside {[99:101]}, 1);
    @(negedge mclk);
    src = 0;
    @(posedge mclk);
    #1;
    chk("rd pulse", rd_v, 0);
    await(5, 400);
    t0 = cyc;
    await(6, 400);
    chk("contact", (cyc - t0) inside {[HC0-1:HC0+1]}, 1);
    await(7, 1300);
    chk("contact 1", (cyc - trel) inside {[HC1-1:HC1+1]}, 1);
    await(8, 18100);
    chk("contact 2", (cyc - trel) inside {[HC2-1:HC2+1]}, 1);
    await(3, 20100);
    chk("second", (cyc - trel) inside {[SEC-1:SEC+1]}, 1);
    @(posedge mclk);
    #1;
    chk("seconds", secs, 1);
    chk("minute contact", ct[3], 0);
    chk("no trip", wd.wd_fault, 0);
    @(negedge mclk);
    ctl = '{cs_enable: 1'b1, cs_period_ms: 8'h02};
    await(0, 500);
    await(0, 500);
    t0 = cyc;
    await(0, 500);
    chk("period", (cyc - t0) inside {[199:210]}, 1);
    dly = 300;
    await(4, 1500);
    await(0, 500);
    @(posedge mclk);
    #1;
    chk("flag", swp.oversweep_flag, 1);
    @(negedge mclk);
    ctl.cs_enable = 0;
    @(posedge mclk);
    #1;
    chk("flag off", swp.oversweep_flag, 0);
    await(0, 500);
    // the sweep just started never completes
    dly = 1000000;
    t0 = cyc;
    await(1, 4100);
    chk("stage one", (cyc - t0) inside {[3996:4008]}, 1);
    t0 = cyc;
    await(2, 4300);
    chk("stage two", (cyc - t0) inside {[4196:4210]}, 1);
    @(posedge mclk);
    #1;
    chk("fault", wd.wd_fault, 1);
    chk("halted", wd.halted, 1);
    @(negedge mclk);
    arst_n = 0;
    repeat (10) @(negedge mclk);
    arst_n = 1;
    chk("fault clr", wd.wd_fault, 0);
    chk("secs clr", secs, 0);
    await(0, 20);
    chk("halt clr", wd.halted, 0);
    tally_and_finish();
  end
endmodule // sts_sweep_timing_supervisor_tb
